// File: rtl/adcts_core.v
// Converter control with threshold scan, result buffer and AHB-Lite register slave
`timescale 1ns/1ps
`include "adcts_defines.vh"

module adcts_core (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata_ff,
   output reg hreadyout_ff,
   output reg hresp_ff,
   input wire cmp_above,
   input wire ext_trig,
   input wire rc_tick,
   output reg sample_en_ff,
   output reg [11:0] dac_code_ff,
   output reg [4:0] ch_sel_ff,
   output reg [2:0] vref_sel_ff,
   output reg charge_unit_drive_ff,
   output reg irq_ff
);

   //------------------------------------------------------------
   // Local states and functions
   //------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SAMPLE = 4'h2;
   localparam [3:0] ST_CONVERT = 4'h4;
   localparam [3:0] ST_STORE = 4'h8;

   // First enabled channel at or above the start point, wrapping
   function [5:0] next_chan;
      input [31:0] mask;
      input [4:0] from;
      integer i;
      reg [4:0] idx;
      begin
         next_chan = 6'h00;
         for (i = 31; i >= 0; i = i - 1) begin
            idx = from + i[4:0];
            if (mask[idx]) begin
               next_chan = {1'b1, idx};
            end
         end
      end
   endfunction

   // Result alignment into a buffer word
   function [15:0] fmt_res;
      input [1:0] form;
      input [11:0] r;
      begin
         case (form)
            2'h0: fmt_res = {4'h0, r};
            2'h1: fmt_res = {{5{~r[11]}}, r[10:0]};
            2'h2: fmt_res = {r, 4'h0};
            default: fmt_res = {~r[11], r[10:0], 4'h0};
         endcase
      end
   endfunction

   // Threshold test on the raw result
   function thr_hit;
      input [1:0] mode;
      input [11:0] r;
      input [11:0] t0;
      input [11:0] t1;
      begin
         case (mode)
            `ADCTS_CM_LESS: thr_hit = (r < t0);
            `ADCTS_CM_GREATER: thr_hit = (r > t0);
            `ADCTS_CM_INSIDE: thr_hit = (r >= t0) && (r <= t1);
            default: thr_hit = (r < t0) || (r > t1);
         endcase
      end
   endfunction

   //------------------------------------------------------------
   // Storage
   //------------------------------------------------------------
   reg [15:0] ctrl1_ff; // Control one, less samp and done
   reg samp_ff; // Sampling bit, hardware set and cleared
   reg done_ff; // Conversion done, set wins over clear
   reg [15:0] ctrl2_ff;
   reg [15:0] ctrl3_ff;
   reg [15:0] ctrl5_ff;
   reg [4:0] chsel_ff; // Channel for single conversions
   reg [31:0] hit_ff; // Threshold hit semaphores
   reg [31:0] scan_ff; // Scan select, high and low halves
   reg [31:0] chg_ff; // Charge unit enables
   reg [1:0] int_stat_ff; // Bit0 conversion rate, bit1 hit
   reg [1:0] int_mask_ff;
   reg [15:0] buf_mem [0:31]; // One word per channel
   reg [3:0] state_ff;
   reg [4:0] ch_ff; // Channel under conversion
   reg [4:0] scan_ptr_ff; // Next scan search start
   reg [3:0] bit_ff; // SAR bit under trial
   reg [7:0] div_ff; // Conversion clock divider
   reg [4:0] samc_ff; // Auto-sample length counter
   reg [4:0] conv_cnt_ff; // Conversions since last interrupt
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [7:0] addr_ff;
   reg [31:0] rd_mux;

   //------------------------------------------------------------
   // Decoded control fields
   //------------------------------------------------------------
   wire mod_on = ctrl1_ff[`ADCTS_ON_BIT];
   wire [1:0] form = ctrl1_ff[`ADCTS_FORM_HI:`ADCTS_FORM_LO];
   wire [3:0] ssrc = ctrl1_ff[`ADCTS_SSRC_HI:`ADCTS_SSRC_LO];
   wire asam = ctrl1_ff[`ADCTS_ASAM_BIT];
   wire [4:0] smpi = ctrl2_ff[`ADCTS_SMPI_HI:`ADCTS_SMPI_LO];
   wire [4:0] samc = ctrl3_ff[`ADCTS_SAMC_HI:`ADCTS_SAMC_LO];
   wire [7:0] tdiv = ctrl3_ff[`ADCTS_DIV_HI:`ADCTS_DIV_LO];
   wire auto_scan_enable = ctrl5_ff[`ADCTS_AUTO_SCAN_ENABLE_BIT];
   wire [1:0] cmode = ctrl5_ff[`ADCTS_CM_HI:`ADCTS_CM_LO];
   wire [5:0] nxt_scan = next_chan(scan_ff, scan_ptr_ff);
   wire [4:0] ch_up = ch_ff + 5'h01;
   wire hit_now = thr_hit(cmode, dac_code_ff, buf_mem[ch_ff][11:0], buf_mem[ch_up][11:0]);
   wire [15:0] res_word = fmt_res(form, dac_code_ff);

   // Conversion clock tick: divided hclk or the RC source
   wire tad_tick = ctrl3_ff[`ADCTS_RCSEL_BIT] ? rc_tick : (div_ff == tdiv);

   //------------------------------------------------------------
   // AHB-Lite slave: zero-wait writes, one-wait reads
   //------------------------------------------------------------
   wire acc = hsel & hready & htrans[1];
   wire wr = wr_pend_ff;
   wire [5:0] widx = addr_ff[7:2];
   wire wr_reg = wr & ~addr_ff[7];
   wire [15:0] wd = hwdata[15:0];

   // Capture address phase and pace the answer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
         hrdata_ff <= 32'h00000000;
      end else if (clk_en) begin
         wr_pend_ff <= acc & hwrite;
         rd_pend_ff <= acc & ~hwrite;
         if (acc) begin
            addr_ff <= haddr[7:0];
         end
         hreadyout_ff <= ~(acc & ~hwrite);
         if (rd_pend_ff) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   // Read multiplexer, unmapped words read zero
   always @* begin
      rd_mux = 32'h00000000;
      if (addr_ff[7]) begin
         rd_mux = {16'h0000, buf_mem[addr_ff[6:2]]};
      end else begin
         case (widx)
            `ADCTS_IDX_CTRL_ONE: rd_mux = {16'h0000, ctrl1_ff[15:2], samp_ff, done_ff};
            `ADCTS_IDX_CTRL_TWO: rd_mux = {16'h0000, ctrl2_ff};
            `ADCTS_IDX_CTRL_THREE: rd_mux = {16'h0000, ctrl3_ff};
            `ADCTS_IDX_CTRL_FIVE: rd_mux = {16'h0000, ctrl5_ff};
            `ADCTS_IDX_CHAN_SEL: rd_mux = {27'h0000000, chsel_ff};
            `ADCTS_IDX_HIT_LOW: rd_mux = {16'h0000, hit_ff[15:0]};
            `ADCTS_IDX_HIT_HIGH: rd_mux = {16'h0000, hit_ff[31:16]};
            `ADCTS_IDX_SCAN_LOW: rd_mux = {16'h0000, scan_ff[15:0]};
            `ADCTS_IDX_SCAN_HIGH: rd_mux = {16'h0000, scan_ff[31:16]};
            `ADCTS_IDX_CHG_LOW: rd_mux = {16'h0000, chg_ff[15:0]};
            `ADCTS_IDX_CHG_HIGH: rd_mux = {16'h0000, chg_ff[31:16]};
            `ADCTS_IDX_INT_STAT: rd_mux = {30'h00000000, int_stat_ff};
            `ADCTS_IDX_INT_MASK: rd_mux = {30'h00000000, int_mask_ff};
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   //------------------------------------------------------------
   // Result buffer: software only while off, hardware only while on
   //------------------------------------------------------------
   always @(posedge hclk) begin
      if (clk_en) begin
         if (wr & addr_ff[7] & ~mod_on) begin
            buf_mem[addr_ff[6:2]] <= wd; // Threshold programming
         end else if (mod_on && state_ff == ST_STORE && (!auto_scan_enable || hit_now)) begin
            buf_mem[ch_ff] <= res_word; // Result to own word
         end
      end
   end

   //------------------------------------------------------------
   // Plain software registers
   //------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1_ff <= `ADCTS_RESET_WORD;
         ctrl2_ff <= `ADCTS_RESET_WORD;
         ctrl3_ff <= `ADCTS_RESET_WORD;
         ctrl5_ff <= `ADCTS_RESET_WORD;
         chsel_ff <= 5'h00;
         scan_ff <= 32'h00000000;
         chg_ff <= 32'h00000000;
         int_mask_ff <= 2'h0;
      end else if (clk_en && wr_reg) begin
         case (widx)
            `ADCTS_IDX_CTRL_ONE: ctrl1_ff <= wd & `ADCTS_MASK_CTRL_ONE;
            `ADCTS_IDX_CTRL_TWO: ctrl2_ff <= wd & `ADCTS_MASK_CTRL_TWO;
            `ADCTS_IDX_CTRL_THREE: ctrl3_ff <= wd & `ADCTS_MASK_CTRL_THREE;
            `ADCTS_IDX_CTRL_FIVE: ctrl5_ff <= wd & `ADCTS_MASK_CTRL_FIVE;
            `ADCTS_IDX_CHAN_SEL: chsel_ff <= wd[4:0];
            `ADCTS_IDX_SCAN_LOW: scan_ff[15:0] <= wd;
            `ADCTS_IDX_SCAN_HIGH: scan_ff[31:16] <= wd;
            `ADCTS_IDX_CHG_LOW: chg_ff[15:0] <= wd;
            `ADCTS_IDX_CHG_HIGH: chg_ff[31:16] <= wd;
            `ADCTS_IDX_INT_MASK: int_mask_ff <= wd[1:0];
            default: int_mask_ff <= int_mask_ff;
         endcase
      end
   end

   //------------------------------------------------------------
   // Sequencer, SAR, flags and interrupt
   //------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_IDLE;
         samp_ff <= 1'b0;
         done_ff <= 1'b0;
         hit_ff <= 32'h00000000;
         int_stat_ff <= 2'h0;
         ch_ff <= 5'h00;
         scan_ptr_ff <= 5'h00;
         bit_ff <= 4'h0;
         div_ff <= 8'h00;
         samc_ff <= 5'h00;
         conv_cnt_ff <= 5'h00;
         sample_en_ff <= 1'b0;
         dac_code_ff <= 12'h000;
         ch_sel_ff <= 5'h00;
         vref_sel_ff <= 3'h0;
         charge_unit_drive_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else if (clk_en) begin
         // Software side of the flags; hardware sets below win
         if (wr_reg && widx == `ADCTS_IDX_CTRL_ONE) begin
            samp_ff <= wd[`ADCTS_SAMP_BIT];
            if (!wd[`ADCTS_DONE_BIT]) begin
               done_ff <= 1'b0;
            end
         end
         if (wr_reg && widx == `ADCTS_IDX_HIT_LOW) begin
            hit_ff[15:0] <= hit_ff[15:0] & ~wd;
         end
         if (wr_reg && widx == `ADCTS_IDX_HIT_HIGH) begin
            hit_ff[31:16] <= hit_ff[31:16] & ~wd;
         end
         if (wr_reg && widx == `ADCTS_IDX_INT_STAT) begin
            int_stat_ff <= int_stat_ff & ~wd[1:0];
         end
         vref_sel_ff <= ctrl2_ff[`ADCTS_VREF_HI:`ADCTS_VREF_LO];
         ch_sel_ff <= ch_ff;
         // Charge unit follows the channel while it is sampled or converted
         charge_unit_drive_ff <= mod_on & chg_ff[ch_ff] & (state_ff[1] | state_ff[2]);
         irq_ff <= |(int_stat_ff & int_mask_ff);
         // Divider runs freely, restarting on each tick
         div_ff <= tad_tick ? 8'h00 : div_ff + 8'h01;
         if (!mod_on) begin
            // Off: stop the sequence, buffer untouched
            state_ff <= ST_IDLE;
            sample_en_ff <= 1'b0;
         end else begin
            case (state_ff)
               ST_IDLE: begin
                  // Start when sampling is requested or automatic
                  if (asam | samp_ff) begin
                     if (!auto_scan_enable) begin
                        ch_ff <= chsel_ff;
                        state_ff <= ST_SAMPLE;
                        sample_en_ff <= 1'b1;
                        samp_ff <= 1'b1;
                        samc_ff <= 5'h00;
                     end else if (nxt_scan[5]) begin
                        ch_ff <= nxt_scan[4:0]; // Ascending scan
                        state_ff <= ST_SAMPLE;
                        sample_en_ff <= 1'b1;
                        samp_ff <= 1'b1;
                        samc_ff <= 5'h00;
                     end
                  end
               end
               ST_SAMPLE: begin
                  if (tad_tick && samc_ff != 5'h1F) begin
                     samc_ff <= samc_ff + 5'h01;
                  end
                  // Trigger source ends sampling
                  if ((ssrc == `ADCTS_SSRC_MANUAL && !samp_ff) ||
                      (ssrc == `ADCTS_SSRC_AUTO && tad_tick && samc_ff + 5'h01 >= samc) ||
                      (ssrc != `ADCTS_SSRC_MANUAL && ssrc != `ADCTS_SSRC_AUTO && ext_trig)) begin
                     state_ff <= ST_CONVERT;
                     sample_en_ff <= 1'b0;
                     samp_ff <= 1'b0;
                     dac_code_ff <= `ADCTS_SAR_MID;
                     bit_ff <= `ADCTS_SAR_MSB;
                  end
               end
               ST_CONVERT: begin
                  // One bit decided per conversion clock
                  if (tad_tick) begin
                     dac_code_ff[bit_ff] <= cmp_above;
                     if (bit_ff != 4'h0) begin
                        dac_code_ff[bit_ff - 4'h1] <= 1'b1;
                        bit_ff <= bit_ff - 4'h1;
                     end else begin
                        state_ff <= ST_STORE;
                     end
                  end
               end
               ST_STORE: begin
                  state_ff <= ST_IDLE;
                  done_ff <= 1'b1;
                  scan_ptr_ff <= ch_up;
                  if (auto_scan_enable && hit_now) begin
                     hit_ff[ch_ff] <= 1'b1;
                     int_stat_ff[1] <= 1'b1;
                  end
                  // Interrupt every smpi+1 conversions
                  if (conv_cnt_ff >= smpi) begin
                     conv_cnt_ff <= 5'h00;
                     int_stat_ff[0] <= 1'b1;
                  end else begin
                     conv_cnt_ff <= conv_cnt_ff + 5'h01;
                  end
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// File: rtl/adcts_defines.vh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADCTS_DEFINES_VH
`define ADCTS_DEFINES_VH

// Register word indices (byte address = 4 * index)
`define ADCTS_IDX_CTRL_ONE 6'h00
`define ADCTS_IDX_CTRL_TWO 6'h01
`define ADCTS_IDX_CTRL_THREE 6'h02
`define ADCTS_IDX_CTRL_FIVE 6'h03
`define ADCTS_IDX_CHAN_SEL 6'h04
`define ADCTS_IDX_HIT_LOW 6'h05
`define ADCTS_IDX_HIT_HIGH 6'h06
`define ADCTS_IDX_SCAN_LOW 6'h07
`define ADCTS_IDX_SCAN_HIGH 6'h08
`define ADCTS_IDX_CHG_LOW 6'h09
`define ADCTS_IDX_CHG_HIGH 6'h0A
`define ADCTS_IDX_INT_STAT 6'h0B
`define ADCTS_IDX_INT_MASK 6'h0C
// Buffer words occupy byte addresses 0x80..0xFC (address bit 7 set)

// Writable masks of control registers
`define ADCTS_MASK_CTRL_ONE 16'h83F4
`define ADCTS_MASK_CTRL_TWO 16'hE07C
`define ADCTS_MASK_CTRL_THREE 16'h9FFF
`define ADCTS_MASK_CTRL_FIVE 16'h8003
`define ADCTS_RESET_WORD 16'h0000

// Field positions
`define ADCTS_ON_BIT 15
`define ADCTS_FORM_HI 9
`define ADCTS_FORM_LO 8
`define ADCTS_SSRC_HI 7
`define ADCTS_SSRC_LO 4
`define ADCTS_ASAM_BIT 2
`define ADCTS_SAMP_BIT 1
`define ADCTS_DONE_BIT 0
`define ADCTS_VREF_HI 15
`define ADCTS_VREF_LO 13
`define ADCTS_SMPI_HI 6
`define ADCTS_SMPI_LO 2
`define ADCTS_RCSEL_BIT 15
`define ADCTS_SAMC_HI 12
`define ADCTS_SAMC_LO 8
`define ADCTS_DIV_HI 7
`define ADCTS_DIV_LO 0
`define ADCTS_AUTO_SCAN_ENABLE_BIT 15
`define ADCTS_CM_HI 1
`define ADCTS_CM_LO 0

// Trigger sources and compare modes
`define ADCTS_SSRC_MANUAL 4'h0
`define ADCTS_SSRC_AUTO 4'h7
`define ADCTS_CM_LESS 2'h0
`define ADCTS_CM_GREATER 2'h1
`define ADCTS_CM_INSIDE 2'h2

// Timing: SAR first trial bit and first trial code
`define ADCTS_SAR_MSB 4'hB
`define ADCTS_SAR_MID 12'h800

`endif

// File: tb/adcts_analog_model.sv
// Behavioural model of the multiplexed analog channels and comparator
`timescale 1ns/1ps

module adcts_analog_model (
   input wire logic [4:0] ch_sel,
   input wire logic [11:0] dac_code,
   output logic cmp_above
);
   // Each channel sits at a fixed level built from its number; ideal comparator
   assign cmp_above = ({ch_sel, 7'h2A} >= dac_code);
endmodule

// File: tb/adcts_core_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps

module adcts_core_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata_ff,
   input wire logic hreadyout_ff,
   input wire logic hresp_ff,
   input wire logic sample_en_ff,
   input wire logic [11:0] dac_code_ff,
   input wire logic [2:0] vref_sel_ff
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   wire logic take = hsel && hready && htrans[1]; // Address phase accepted
   wire logic rd_take = take && !hwrite; // Read accepted
   wire logic wr_take = take && hwrite; // Write accepted
   logic wr2_dp_ff; // Data phase of a write to the second control word
   logic [2:0] vref_want_ff; // Reference field last written

   // Track second control word writes to know the expected reference select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr2_dp_ff <= 1'h0;
         vref_want_ff <= 3'h0;
      end else begin
         wr2_dp_ff <= wr_take && (haddr[7:0] == 8'h04);
         if (wr2_dp_ff) begin
            vref_want_ff <= hwdata[15:13];
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_resp_always_okay: assert property (hresp_ff == 1'h0)
      else $error("Slave gave a non-OKAY response");
   a_write_zero_wait: assert property (wr_take |=> hreadyout_ff)
      else $error("Write data phase stretched");
   a_read_one_wait: assert property (rd_take |=> !hreadyout_ff ##1 hreadyout_ff)
      else $error("Read data phase not exactly one wait");
   a_rdata_upper_zero: assert property (hrdata_ff[31:16] == 16'h0000)
      else $error("Upper read data bits not zero");
   a_rdata_holds: assert property ($changed(hrdata_ff) |-> $rose(hreadyout_ff))
      else $error("Read data moved outside a read completion");
   a_unmapped_reads_zero: assert property (
      rd_take && !haddr[7] && (haddr[7:2] > 6'h0C) |-> ##2 hrdata_ff == 32'h0)
      else $error("Unmapped read returned nonzero");
   a_vref_follows_write: assert property (
      wr2_dp_ff |=> ##[0:1] vref_sel_ff == vref_want_ff)
      else $error("Reference select does not follow its field");
   a_dac_holds_sampling: assert property (
      sample_en_ff && $past(sample_en_ff) |-> $stable(dac_code_ff))
      else $error("Trial code moved during sampling");
endmodule

// File: tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD at %0t got %h exp %h", $time, (g), (e)); end end

module testbench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic hclk = 1'h0; // Bus clock
   logic hresetn = 1'h0; // Reset, active low
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic rc_tick = 1'h0; // Internal RC clock tick
   logic clk_en = 1'h1; // Clock enable, low freezes the block
   logic ext_trig = 1'h0; // External conversion trigger
   logic smp_d = 1'h0; // Sample enable one cycle ago
   wire [31:0] hrdata;
   wire hready, hresp, sample_en, cmp_above, charge_drive, irq;
   wire [11:0] dac_code;
   wire [4:0] ch_sel;
   wire [2:0] vref_sel;
   int mismatches = 0;
   int n_checks = 0;
   int n_drv2 = 0; // Charge drive cycles seen on channel 2
   int n_drv4 = 0; // Charge drive cycles seen on channel 4
   int k;
   int hit;
   logic [31:0] q;
   logic [4:0] log_ch [$]; // Channel at the end of each sample

   always #10 hclk = ~hclk;
   // RC tick on every second edge
   always @(posedge hclk) rc_tick <= ~rc_tick;

   adcts_core u_adcts_core (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata_ff(hrdata), .hreadyout_ff(hready), .hresp_ff(hresp),
      .cmp_above(cmp_above), .ext_trig(ext_trig), .rc_tick(rc_tick), .sample_en_ff(sample_en),
      .dac_code_ff(dac_code), .ch_sel_ff(ch_sel), .vref_sel_ff(vref_sel),
      .charge_unit_drive_ff(charge_drive), .irq_ff(irq));
   adcts_analog_model u_adcts_analog_model (.ch_sel(ch_sel), .dac_code(dac_code),
      .cmp_above(cmp_above));

   // Log scan order and charge drive where outputs are settled
   always @(negedge hclk) begin
      if (smp_d && !sample_en) log_ch.push_back(ch_sel);
      if (charge_drive && sample_en && ch_sel == 5'h2) n_drv2++;
      if (charge_drive && sample_en && ch_sel == 5'h4) n_drv4++;
      smp_d <= sample_en;
   end

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   // One single AHB-Lite transfer, entered just after a rising edge; hready and
   // read data are taken at rising edges
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // Start a conversion and poll the done flag
   task automatic conv(input logic [15:0] c);
      wr(8'h00, {16'h0, c});
      do xfer(1'h0, 8'h00, 32'h0, q); while (q[0] !== 1'h1);
   endtask
   // Expected buffer word of a channel 5 result in each format
   function automatic logic [31:0] fmt(input int f);
      logic [11:0] s;
      s = 12'h2AA - 12'h800;
      case (f)
         0: fmt = 32'h2AA;
         1: fmt = {16'h0, {4{s[11]}}, s};
         2: fmt = {16'h0, 12'h2AA, 4'h0};
         default: fmt = {16'h0, s, 4'h0};
      endcase
   endfunction

   task close_out;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake or conversion
   initial begin
      #2000000;
      mismatches++;
      close_out();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      for (k = 0; k < 13; k++) rc(8'(k * 4), 32'h0);
      wr(8'h7C, 32'hFFFF);
      rc(8'h7C, 32'h0);
      wr(8'h04, 32'hFFFF);
      rc(8'h04, 32'hE07C);
      `CHK(vref_sel, 3'h7)
      wr(8'h04, 32'h0);
      wr(8'h08, 32'hFFFF);
      rc(8'h08, 32'h9FFF);
      wr(8'h0C, 32'hFFFF);
      rc(8'h0C, 32'h8003);
      wr(8'h0C, 32'h0);
      wr(8'h00, 32'h03F4);
      rc(8'h00, 32'h03F4);
      wr(8'h00, 32'h0);
      for (k = 0; k < 32; k++) wr(8'(8'h80 + k * 4), 32'(32'hA00 + k));
      for (k = 0; k < 32; k++) rc(8'(8'h80 + k * 4), 32'(32'hA00 + k));
      // Single conversions on channel 5 in every format, last one on RC ticks
      wr(8'h10, 32'h5);
      wr(8'h08, 32'h0201);
      for (k = 0; k < 4; k++) begin
         if (k == 3) wr(8'h08, 32'h8201);
         conv(16'h8072 | 16'(k << 8));
         wr(8'h94, 32'hFFF);
         rc(8'h94, fmt(k));
         wr(8'h00, 32'h0);
         rc(8'h94, fmt(k));
      end
      // Interrupt: raised, masked, cleared
      rc(8'h2C, 32'h1);
      `CHK(irq, 1'h0)
      wr(8'h30, 32'h1);
      rc(8'h30, 32'h1);
      `CHK(irq, 1'h1)
      wr(8'h2C, 32'h1);
      rc(8'h2C, 32'h0);
      `CHK(irq, 1'h0)
      // Rate of one event every two conversions
      wr(8'h04, 32'h4);
      do begin
         conv(16'h8072);
         xfer(1'h0, 8'h2C, 32'h0, q);
      end while (q[0] !== 1'h1);
      wr(8'h2C, 32'h1);
      conv(16'h8072);
      rc(8'h2C, 32'h0);
      conv(16'h8072);
      rc(8'h2C, 32'h1);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h30, 32'h0);
      // Threshold scan of channels 2 and 4 in every compare mode
      wr(8'h1C, 32'h14);
      wr(8'h24, 32'h10);
      for (k = 0; k < 4; k++) begin
         wr(8'h88, 32'h100);
         wr(8'h8C, 32'h200);
         wr(8'h90, k < 2 ? 32'h300 : 32'h0);
         wr(8'h94, 32'h100);
         wr(8'h14, 32'hFFFF);
         wr(8'h2C, 32'hFFFF);
         wr(8'h0C, 32'(32'h8000 + k));
         log_ch.delete();
         wr(8'h00, 32'h8074);
         while (log_ch.size() < 3) @(posedge hclk);
         wr(8'h00, 32'h0);
         hit = (k == 0 || k == 3) ? 4 : 2;
         `CHK(log_ch[0], 5'h2)
         `CHK(log_ch[1], 5'h4)
         rc(8'h14, 32'h1 << hit);
         rc(8'h88, hit == 2 ? 32'h12A : 32'h100);
         rc(8'h90, hit == 4 ? 32'h22A : (k < 2 ? 32'h300 : 32'h0));
         xfer(1'h0, 8'h2C, 32'h0, q);
         `CHK(q[1], 1'h1)
      end
      // Manual trigger, then an external trigger held off by a frozen clock enable
      wr(8'h0C, 32'h0);
      for (k = 0; k < 2; k++) begin
         wr(8'h94, 32'h0);
         wr(8'h00, k ? 32'h8012 : 32'h8002);
         repeat (40) @(posedge hclk);
         `CHK(sample_en, 1'h1)
         if (k == 0) begin
            wr(8'h00, 32'h8000);
         end else begin
            clk_en <= 1'h0;
            ext_trig <= 1'h1;
            repeat (4) @(posedge hclk);
            `CHK(sample_en, 1'h1)
            clk_en <= 1'h1;
            @(posedge hclk);
            ext_trig <= 1'h0;
         end
         do xfer(1'h0, 8'h00, 32'h0, q); while (q[0] !== 1'h1);
         rc(8'h94, 32'h2AA);
         wr(8'h00, 32'h0);
      end
      `CHK(n_drv4 > n_drv2, 1'h1)
      close_out();
   end
endmodule

bind adcts_core adcts_core_checker u_adcts_core_checker (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
   .sample_en_ff(sample_en_ff), .dac_code_ff(dac_code_ff), .vref_sel_ff(vref_sel_ff));
